// [pkg/smrp_consts.vh]
// Constants for the serial memory read path with pause control
`ifndef SMRP_CONSTS_VH
`define SMRP_CONSTS_VH
`define SMRP_FETCH_OPCODE 8'h03
`define SMRP_ADDR_W       13
`define SMRP_LAST_ADDR    13'h1FFF
`define SMRP_FIRST_ADDR   13'h0000
`define SMRP_MEM_DEPTH    8192
`define SMRP_BITS_BYTE    4'h8
`define SMRP_HDR_BITS     6'h18
`define SMRP_FIFO_DEPTH   8
`define SMRP_FIFO_AW      3
`endif

// [verilog/smrp_fifo.v]
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module smrp_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             i_core_clk,
   input  wire             i_rst_n,
   input  wire             i_clear,
   input  wire [WIDTH-1:0] i_in_data,
   input  wire             i_in_valid,
   output wire             o_in_ready,
   output wire [WIDTH-1:0] o_out_data,
   output wire             o_out_valid,
   input  wire             i_out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr;
   reg [AW:0]      rd_ptr;
   wire            full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire            empty = (wr_ptr == rd_ptr);
   wire            push  = i_in_valid && !full;
   wire            pop   = i_out_ready && !empty;
   assign o_in_ready  = !full;
   assign o_out_valid = !empty;
   assign o_out_data  = mem[rd_ptr[AW-1:0]];
   always @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_in_data;
      end
   end
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else if (i_clear) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // smrp_fifo

// [verilog/smrp_read.v]
// Serial memory slave: fetch command, address, sequential read stream, pause
// Operation
// - Two address bytes collected; upper three bits dropped, low thirteen used.
// - After command and address, serial input is ignored until deselect.
// - Each byte takes eight serial clocks, one output bit per clock.
// - Address advances by one per byte while clocking continues.
// - Address past 1FFFh wraps to 0000h.
// - Bytes are shifted out most significant bit first.
// - Select rising ends the transaction at any bit position.
// - Pause going low with clock low freezes all transfer state.
// - Pause returning high with clock low resumes exactly where stopped.
// - While paused, clock toggles shift nothing and advance no counter.
// - Fetch command is 0000 0011b and starts a sequential read.
// - Input sampled on rising clock edge, output updated on falling edge.
`timescale 1ns/1ps
`include "smrp_consts.vh"
module smrp_read (
   input  wire        i_core_clk,
   input  wire        i_rst_n,
   input  wire        i_sclk,
   input  wire        i_cs_n,
   input  wire        i_sdi,
   input  wire        i_pause_n,
   output reg         o_sdo,
   output reg         o_sdo_oe,
   input  wire        i_load_we,
   input  wire [12:0] i_load_addr,
   input  wire [7:0]  i_load_data,
   output wire        o_busy
);
   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   reg [1:0] sclk_s;
   reg [1:0] cs_s;
   reg [1:0] sdi_s;
   reg [1:0] pause_s;
   reg       sclk_d;
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sclk_s  <= 2'h0;
         cs_s    <= 2'h3;
         sdi_s   <= 2'h0;
         pause_s <= 2'h3;
         sclk_d  <= 1'b0;
      end else begin
         sclk_s  <= {sclk_s[0], i_sclk};
         cs_s    <= {cs_s[0], i_cs_n};
         sdi_s   <= {sdi_s[0], i_sdi};
         pause_s <= {pause_s[0], i_pause_n};
         sclk_d  <= sclk_s[1];
      end
   end
   wire sclk_q  = sclk_s[1];
   wire cs_q    = cs_s[1];
   wire sdi_q   = sdi_s[1];
   wire pause_q = pause_s[1];
   wire rise    = sclk_q && !sclk_d;
   wire fall    = !sclk_q && sclk_d;

   // ****************************************************************
   // Pause latch, changes only while clock is low, cleared at any time by deselect
   // ****************************************************************
   reg paused;
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         paused <= 1'b0;
      end else if (cs_q) begin
         paused <= 1'b0;
      end else if (!sclk_q && !sclk_d) begin
         paused <= !pause_q;
      end
   end

   // ****************************************************************
   // Memory array
   // ****************************************************************
   reg [7:0] mem [0:`SMRP_MEM_DEPTH-1];
   reg [12:0] rd_addr;
   // Unregistered read: a registered copy would lag rd_addr by one push
   // and hand the FIFO the same byte twice
   wire [7:0] rd_byte = mem[rd_addr];
   always @(posedge i_core_clk) begin
      if (i_load_we) begin
         mem[i_load_addr] <= i_load_data;
      end
   end

   // ****************************************************************
   // Transaction state
   // ****************************************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_HDR  = 2'h1;
   localparam ST_DATA = 2'h2;
   localparam ST_SKIP = 2'h3;

   reg [1:0]  state;
   reg [5:0]  hdr_cnt;
   reg [23:0] hdr_sr;
   reg [2:0]  bit_idx;
   reg [7:0]  out_sr;
   reg        fetch_req;
   reg        fetch_rdy;
   wire [23:0] next_hdr = {hdr_sr[22:0], sdi_q};
   wire        clk_ok   = !cs_q && !paused;

   // Prefetch FIFO: bytes read ahead of the serial stream
   wire       ff_in_ready;
   wire [7:0] ff_data;
   wire       ff_valid;
   reg        ff_pop;
   reg        ff_push;
   smrp_fifo #(
      .WIDTH (8),
      .DEPTH (`SMRP_FIFO_DEPTH),
      .AW    (`SMRP_FIFO_AW)
   ) u_fifo (
      .i_core_clk  (i_core_clk),
      .i_rst_n     (i_rst_n),
      .i_clear     (cs_q),
      .i_in_data   (rd_byte),
      .i_in_valid  (ff_push),
      .o_in_ready  (ff_in_ready),
      .o_out_data  (ff_data),
      .o_out_valid (ff_valid),
      .i_out_ready (ff_pop)
   );

   // Array reads run at core rate, far ahead of the serial clock, so the
   // FIFO stays full and a byte is always ready at a byte boundary.
   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ff_push   <= 1'b0;
         fetch_rdy <= 1'b0;
      end else begin
         fetch_rdy <= fetch_req && !cs_q && ff_in_ready && !ff_push;
         ff_push   <= fetch_rdy && ff_in_ready && !cs_q;
      end
   end

   always @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state     <= ST_IDLE;
         hdr_cnt   <= 6'h00;
         hdr_sr    <= 24'h000000;
         bit_idx   <= 3'h0;
         out_sr    <= 8'h00;
         rd_addr   <= `SMRP_FIRST_ADDR;
         fetch_req <= 1'b0;
         ff_pop    <= 1'b0;
         o_sdo     <= 1'b0;
         o_sdo_oe  <= 1'b0;
      end else begin
         ff_pop <= 1'b0;
         // A push refused by a full FIFO keeps the address, so the byte is retried
         if (ff_push && ff_in_ready) begin
            if (rd_addr == `SMRP_LAST_ADDR) begin
               rd_addr <= `SMRP_FIRST_ADDR;
            end else begin
               rd_addr <= rd_addr + 13'h0001;
            end
         end
         if (cs_q) begin
            state     <= ST_IDLE;
            hdr_cnt   <= 6'h00;
            bit_idx   <= 3'h0;
            fetch_req <= 1'b0;
            o_sdo_oe  <= 1'b0;
         end else begin
            o_sdo_oe <= (state == ST_DATA) && !paused;
            case (state)
               ST_IDLE: begin
                  state   <= ST_HDR;
                  hdr_cnt <= 6'h00;
               end
               ST_HDR: begin
                  if (rise && clk_ok) begin
                     hdr_sr  <= next_hdr;
                     hdr_cnt <= hdr_cnt + 6'h01;
                     if (hdr_cnt == 6'h07 && next_hdr[7:0] != `SMRP_FETCH_OPCODE) begin
                        state <= ST_SKIP;
                     end else if (hdr_cnt == `SMRP_HDR_BITS - 6'h01) begin
                        rd_addr   <= next_hdr[12:0];
                        fetch_req <= 1'b1;
                        state     <= ST_DATA;
                        bit_idx   <= 3'h0;
                     end
                  end
               end
               ST_DATA: begin
                  if (fall && clk_ok && ff_valid && !ff_pop) begin
                     if (bit_idx == 3'h0) begin
                        o_sdo  <= ff_data[7];
                        out_sr <= {ff_data[6:0], 1'b0};
                        ff_pop <= 1'b1;
                     end else begin
                        o_sdo  <= out_sr[7];
                        out_sr <= {out_sr[6:0], 1'b0};
                     end
                     bit_idx <= bit_idx + 3'h1;
                  end
               end
               ST_SKIP: begin
                  hdr_cnt <= hdr_cnt;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   assign o_busy = (state != ST_IDLE);
endmodule // smrp_read

// [sim/smrp_read_properties.sv]
// Concurrent checks on the serial read port
`timescale 1ns/1ps
`include "smrp_consts.vh"
module smrp_read_properties (
   input wire i_core_clk,
   input wire i_rst_n,
   input wire i_sclk,
   input wire i_cs_n,
   input wire i_sdi,
   input wire i_pause_n,
   input wire o_sdo,
   input wire o_sdo_oe,
   input wire o_busy
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   logic [5:0] rises;
   logic [7:0] op;
   logic [3:0] since_fall;
   // Edges taken while paused are not counted, as in the device
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rises <= 6'h00;
         op <= 8'h00;
         since_fall <= 4'hF;
      end else begin
         since_fall <= $fell(i_sclk) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hF};
         if (i_cs_n)
            rises <= 6'h00;
         else if ($rose(i_sclk) && i_pause_n && rises != 6'h3F)
            rises <= rises + 6'h01;
         if (!i_cs_n && $rose(i_sclk) && rises < 6'h08)
            op <= {op[6:0], i_sdi};
      end
   end
   sequence s_idle; i_cs_n [*6]; endsequence
   sequence s_paused; !i_pause_n [*6]; endsequence
   property p_idle; s_idle |-> !o_sdo_oe && !o_busy; endproperty
   a_idle: assert property (p_idle)
      else $error("output driven while deselected");
   property p_end; $rose(i_cs_n) |-> ##[1:5] !o_sdo_oe; endproperty
   a_end: assert property (p_end)
      else $error("deselect did not end the read");
   property p_pause_off; s_paused |-> !o_sdo_oe; endproperty
   a_pause_off: assert property (p_pause_off)
      else $error("output driven during pause");
   property p_pause_still; s_paused |=> $stable(o_sdo); endproperty
   a_pause_still: assert property (p_pause_still)
      else $error("data moved during pause");
   property p_fall; o_sdo_oe && $changed(o_sdo) |-> since_fall <= 4'h6; endproperty
   a_fall: assert property (p_fall)
      else $error("data changed away from a falling clock");
   property p_header; $rose(o_sdo_oe) |-> rises >= 6'd24; endproperty
   a_header: assert property (p_header)
      else $error("data before command and address");
   property p_opcode; $rose(o_sdo_oe) |-> op == `SMRP_FETCH_OPCODE; endproperty
   a_opcode: assert property (p_opcode)
      else $error("data after a foreign command");
   property p_resume;
      $rose(i_pause_n) && !i_cs_n && rises > 6'd24 && op == `SMRP_FETCH_OPCODE
         |-> ##[1:8] o_sdo_oe;
   endproperty
   a_resume: assert property (p_resume)
      else $error("read did not resume");
endmodule // smrp_read_properties
bind smrp_read smrp_read_properties i_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
   .i_sclk(i_sclk), .i_cs_n(i_cs_n), .i_sdi(i_sdi), .i_pause_n(i_pause_n),
   .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_busy(o_busy));

// [sim/smrp_master.sv]
// Bus master model driving the serial read port
`timescale 1ns/1ps
module smrp_master (
   input  wire logic i_core_clk,
   input  wire logic i_sdo,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_sdi,
   output logic      o_pause_n
);
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi = 1'b0;
      o_pause_n = 1'b1;
   end
   task automatic half(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // Data is taken just before the fall, while the previous bit still stands
   task automatic bit_io(input logic d, output logic q);
      o_sdi <= d;
      half(4);
      o_sclk <= 1'b1;
      half(4);
      q = i_sdo;
      o_sclk <= 1'b0;
   endtask
   task automatic hold();
      half(6);
      o_pause_n <= 1'b0;
      half(8);
      repeat (2) begin
         o_sclk <= 1'b1;
         half(4);
         o_sclk <= 1'b0;
         half(4);
      end
      o_pause_n <= 1'b1;
      half(6);
   endtask
   // After the header the whole header pattern (command, then address) repeats on the input line
   task automatic xfer(input logic [7:0] cmd, input logic [15:0] adr, input int n,
                       input int p, output logic [63:0] data);
      logic [23:0] hdr;
      logic b;
      hdr = {cmd, adr};
      data = 64'h0;
      o_cs_n <= 1'b0;
      for (int i = 0; i < 24 + n; i++) begin
         if (i == p)
            hold();
         bit_io(hdr[23 - (i % 24)], b);
         if (i >= 24)
            data = {data[62:0], b};
      end
      half(2);
      o_cs_n <= 1'b1;
      half(6);
   endtask
endmodule // smrp_master

// [sim/test_serial_memory_read_pause.sv]
// Self-checking bench for the serial read path
`timescale 1ns/1ps
`include "smrp_consts.vh"
module test_serial_memory_read_pause;
   logic clk, rst_n = 0, we = 0, flip = 0, sclk, cs_n, sdi, pause_n, sdo, oe, busy;
   logic [12:0] la = 13'h0000;
   logic [7:0] ld = 8'h00, r8;
   logic [31:0] seed = 32'h25E376E0, r;
   logic [15:0] adr;
   logic [63:0] got;
   logic [7:0] mem [0:`SMRP_MEM_DEPTH-1];
   int fails = 0, checks = 0, cyc = 0, oe_cnt = 0, n, p, c0;
   // Released line shows a moving pattern, not the last bit
   wire sdo_w = oe ? sdo : flip;
   smrp_read i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_sdi(sdi), .i_pause_n(pause_n), .o_sdo(sdo), .o_sdo_oe(oe), .i_load_we(we),
      .i_load_addr(la), .i_load_data(ld), .o_busy(busy));
   smrp_master i_mst (.i_core_clk(clk), .i_sdo(sdo_w), .o_sclk(sclk), .o_cs_n(cs_n),
      .o_sdi(sdi), .o_pause_n(pause_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      flip <= ~flip;
      oe_cnt <= oe_cnt + (oe === 1'b1);
      cyc++;
      if (cyc == 30000) begin
         fails++;
         print_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [63:0] model(input logic [12:0] a, input int n);
      logic [63:0] m = 64'h0;
      for (int k = 0; k < n; k++)
         m = {m[62:0], mem[13'(a + k / 8)][7 - k % 8]};
      return m;
   endfunction
   task automatic cmp(input logic [63:0] exp, input logic [63:0] act);
      checks++;
      if (act !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, act);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ******
   // Preload, then reads with wrap, pause and abort
   // ******
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < `SMRP_MEM_DEPTH; i++) begin
         @(posedge clk);
         r8 = 8'(rnd());
         mem[i] = r8;
         we <= 1'b1;
         la <= 13'(i);
         ld <= r8;
      end
      @(posedge clk);
      we <= 1'b0;
      for (int t = 0; t < 7; t++) begin
         r = rnd();
         adr = (t == 0) ? 16'hFFFE : r[15:0];
         n = (t == 0) ? 32 : 1 + r[21:16];
         p = t[0] ? 25 + r[26:22] : -1;
         i_mst.xfer(`SMRP_FETCH_OPCODE, adr, n, p, got);
         cmp(model(adr[12:0], n), got);
         cmp(64'h0, 64'(busy));
         $display("read test %0d done", t);
      end
      c0 = oe_cnt;
      i_mst.xfer(`SMRP_FETCH_OPCODE ^ (8'h01 << r[2:0]), r[15:0], 16, -1, got);
      cmp(64'(c0), 64'(oe_cnt));
      $display("foreign command test done");
      print_verdict();
   end
endmodule // test_serial_memory_read_pause
